// ### hdl/covm_top.sv
// cell overvoltage monitor: sampling, alarm state, quick test, registers
// assumes comparator and supply levels arrive synchronous to aclk
//
// Function
// [RULE1] sample all cells every 400 ms normally
// [RULE2] sample every 100 ms while alarmed
// [RULE3] qualify 2.0 s to raise, 0.2 s release
// [RULE4] delays may stretch by one period
// [RULE5] override low forces the alarm outputs
// [RULE6] alarm drives high output, open-drain low
// [RULE7] monitor only after regulator recovery
// [RULE8] top cell inactive: no alarm at all; here override low still forces the alarm outputs
// [RULE9] top cell active: detect normally
// [RULE10] quick test: period and delays 100 ms
// [RULE11] override low at power-up enters quick test
// [RULE12] override high then low leaves quick test
// [RULE13] detect 1-5 s, release 0.2-1 s builds
// [RULE14] quick test hold longer than 25 ms
// [RULE15] any cell over raises, all below release
// [RULE16] broken qualification restarts its count
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module covm_top
  import covm_pkg::*;
#(
  parameter int unsigned CNT_W = 32,
  parameter int unsigned DET_STEPS = DET_STEPS_DEF, // 1 s steps, 1 to 5
  parameter int unsigned REL_STEPS = REL_STEPS_DEF, // 0.2 s steps, 1 to 5
  parameter int unsigned NORMAL_CYC = NORMAL_PERIOD_CYC,
  parameter int unsigned ALARM_CYC = ALARM_PERIOD_CYC,
  parameter int unsigned QUICK_CYC = QUICK_CYC_DEF,
  parameter int unsigned TEST_HOLD_CYC = TEST_HOLD_CYC_DEF,
  parameter int unsigned DET_CYC = DET_STEPS * DET_STEP_MS * CYC_PER_MS,
  parameter int unsigned REL_CYC = REL_STEPS * REL_STEP_MS * CYC_PER_MS
) (
  input logic aclk, // 125 MHz clock
  input logic aresetn, // synchronous reset, active low
  input logic cell_over_detect, // any enabled cell above detect level
  input logic cell_below_release, // all cells below release level
  input logic top_cell_tap_active, // top cell above activation level
  input logic regulator_recovered, // regulator above recovery level
  input logic override_n, // external override, low forces alarm
  input logic alarm_low_opendrain_in, // open-drain pin level
  output logic alarm_low_opendrain_out, // open-drain pin value
  output logic alarm_low_opendrain_oe_n, // low while pulling the pin
  output logic alarm_high_output, // high while alarmed
  output logic irq, // level interrupt
  input logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input logic [REG_AW-1:0] s_axi_awaddr, // write address
  input logic [2:0] s_axi_awprot, // write protection, unused
  input logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  input logic [31:0] s_axi_wdata, // write data
  input logic [3:0] s_axi_wstrb, // write byte strobes
  output logic s_axi_bvalid, // write response valid
  input logic s_axi_bready, // write response ready
  output logic [1:0] s_axi_bresp, // write response
  input logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  input logic [REG_AW-1:0] s_axi_araddr, // read address
  input logic [2:0] s_axi_arprot, // read protection, unused
  output logic s_axi_rvalid, // read data valid
  input logic s_axi_rready, // read data ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp // read response
);

  // ****************************************
  // constants and state
  // ****************************************
  // [RULE13] delay build options
  localparam logic [CNT_W-1:0] DET_C = CNT_W'(DET_CYC);
  localparam logic [CNT_W-1:0] REL_C = CNT_W'(REL_CYC);
  localparam logic [CNT_W-1:0] NORMAL_C = CNT_W'(NORMAL_CYC);
  localparam logic [CNT_W-1:0] ALARM_C = CNT_W'(ALARM_CYC);
  localparam logic [CNT_W-1:0] QUICK_C = CNT_W'(QUICK_CYC);
  localparam logic [CNT_W-1:0] HOLD_C = CNT_W'(TEST_HOLD_CYC);

  typedef struct packed {
    covm_state_e st;
    logic quick;
    logic pwr_low;
    logic seen_high;
    logic [CNT_W-1:0] hold;
    logic alarm;
    logic od_val;
    logic od_oe_n;
    logic ctrl_en;
    logic [IRQ_W-1:0] irq_sts;
    logic [IRQ_W-1:0] irq_en;
    logic irq;
    logic aw_have;
    logic [REG_AW-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } covm_top_s;

  covm_top_s r, n;
  logic mon_on;
  logic [IRQ_W-1:0] ev, clr;
  logic [STS_W-1:0] sts;
  covm_sel_e wsel;

  covm_time_if #(.CNT_W(CNT_W)) tif ();

  // word decode shared by reads and writes
  function automatic covm_sel_e covm_reg_idx(input logic [REG_AW-1:0] a);
    case (a[REG_AW-1:2])
      REG_CTRL[REG_AW-1:2]: covm_reg_idx = SEL_CTRL;
      REG_STATUS[REG_AW-1:2]: covm_reg_idx = SEL_STATUS;
      REG_IRQ_STS[REG_AW-1:2]: covm_reg_idx = SEL_IRQ_STS;
      REG_IRQ_EN[REG_AW-1:2]: covm_reg_idx = SEL_IRQ_EN;
      REG_IRQ_CLR[REG_AW-1:2]: covm_reg_idx = SEL_IRQ_CLR;
      default: covm_reg_idx = SEL_NONE;
    endcase
  endfunction

  // ****************************************
  // helpers and their inputs
  // ****************************************
  // [RULE7] gate on regulator recovery
  assign mon_on = regulator_recovered && r.ctrl_en;
  assign tif.run_en = mon_on;

  // [RULE15] select the condition under test
  // [RULE8] inactive top cell hides overvoltage
  assign tif.cond = top_cell_tap_active &&
    (r.st == ST_ALARM ? cell_below_release : cell_over_detect);
  assign tif.restart = (n.st != r.st) || !top_cell_tap_active;

  // [RULE1] normal 400 ms period
  // [RULE2] faster period when alarmed
  // [RULE10] quick test timings
  assign tif.period_cyc = r.quick ? QUICK_C : (r.st == ST_ALARM ? ALARM_C : NORMAL_C);
  // [RULE3] detect and release delays
  assign tif.delay_cyc = r.quick ? QUICK_C : (r.st == ST_ALARM ? REL_C : DET_C);

  covm_sampler #(.CNT_W(CNT_W)) u_sampler (
    .aclk(aclk),
    .aresetn(aresetn),
    .t(tif.sampler)
  );

  covm_qualifier #(.CNT_W(CNT_W)) u_qual (
    .aclk(aclk),
    .aresetn(aresetn),
    .t(tif.qual)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = r;
    ev = '0;
    clr = '0;
    wsel = SEL_NONE;
    sts = '0;

    // quick test entry: low since power-up, held after recovery
    if (override_n) n.pwr_low = 1'b0;
    if (!regulator_recovered) begin
      n.hold = '0;
    end else if (r.pwr_low && !override_n) begin
      // [RULE11] enter quick test
      // [RULE14] hold longer than 25 ms
      if (r.hold == HOLD_C) begin
        n.quick = 1'b1;
        n.pwr_low = 1'b0;
      end else begin
        n.hold = r.hold + 1'b1;
      end
    end

    // [RULE12] leave on high then low
    if (r.quick) begin
      if (override_n) begin
        n.seen_high = 1'b1;
      end else if (r.seen_high) begin
        n.quick = 1'b0;
        n.seen_high = 1'b0;
      end
    end

    // alarm state machine
    case (r.st)
      ST_IDLE: begin
        if (mon_on) n.st = ST_NORMAL;
      end
      // [RULE9] qualified overvoltage raises
      ST_NORMAL: begin
        if (tif.done && top_cell_tap_active) n.st = ST_ALARM;
      end
      ST_ALARM: begin
        if (tif.done) n.st = ST_NORMAL;
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
    // [RULE8] inactive top cell clears alarm
    if (!mon_on) n.st = ST_IDLE;
    else if (!top_cell_tap_active && r.st == ST_ALARM) n.st = ST_NORMAL;

    // [RULE5] override forces the outputs
    // [RULE6] both alarm pins together
    n.alarm = !override_n || n.st == ST_ALARM;
    n.od_oe_n = !n.alarm;
    n.od_val = 1'b0;

    // events for the interrupt status
    ev[IRQ_RAISE] = n.st == ST_ALARM && r.st != ST_ALARM;
    ev[IRQ_RELEASE] = r.st == ST_ALARM && n.st != ST_ALARM;
    ev[IRQ_QENTER] = n.quick && !r.quick;
    ev[IRQ_QEXIT] = r.quick && !n.quick;

    // status word
    sts[STS_ALARM] = r.st == ST_ALARM;
    sts[STS_QUICK] = r.quick;
    sts[STS_MON] = mon_on;
    sts[STS_TOP_ACT] = top_cell_tap_active;
    sts[STS_OVR_LOW] = !override_n;
    sts[STS_PIN] = alarm_low_opendrain_in;

    // write channel: address and data in either order
    if (r.bvalid && s_axi_bready) n.bvalid = 1'b0;
    if (s_axi_awvalid && r.awready) begin
      n.aw_have = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready) begin
      n.w_have = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_lane0 = s_axi_wstrb[0];
    end
    if (n.aw_have && n.w_have && !r.bvalid) begin
      wsel = covm_reg_idx(n.aw_addr);
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (wsel)
        SEL_CTRL: begin
          if (n.w_lane0) n.ctrl_en = n.w_data[CTRL_MON_EN];
        end
        SEL_IRQ_EN: begin
          if (n.w_lane0) n.irq_en = n.w_data[IRQ_W-1:0];
        end
        SEL_IRQ_CLR: begin
          if (n.w_lane0) clr = n.w_data[IRQ_W-1:0];
        end
        SEL_NONE: begin
          n.bresp = RESP_SLVERR;
        end
        default: begin
          n.bresp = RESP_OKAY;
        end
      endcase
    end
    n.awready = !n.aw_have && !n.bvalid;
    n.wready = !n.w_have && !n.bvalid;

    // read channel: one read at a time
    if (r.rvalid && s_axi_rready) n.rvalid = 1'b0;
    if (s_axi_arvalid && r.arready) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = '0;
      case (covm_reg_idx(s_axi_araddr))
        SEL_CTRL: n.rdata[CTRL_MON_EN] = r.ctrl_en;
        SEL_STATUS: n.rdata[STS_W-1:0] = sts;
        SEL_IRQ_STS: n.rdata[IRQ_W-1:0] = r.irq_sts;
        SEL_IRQ_EN: n.rdata[IRQ_W-1:0] = r.irq_en;
        SEL_IRQ_CLR: n.rdata = '0;
        default: n.rresp = RESP_SLVERR;
      endcase
    end
    n.arready = !n.rvalid;

    // sticky status: a new event wins over its clear
    n.irq_sts = (r.irq_sts & ~clr) | ev;
    n.irq = |(n.irq_sts & n.irq_en);
  end

  // ****************************************
  // state register and outputs
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.ctrl_en <= CTRL_MON_EN_RST;
      r.pwr_low <= 1'b1;
      r.od_oe_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign alarm_high_output = r.alarm;
  assign alarm_low_opendrain_out = r.od_val;
  assign alarm_low_opendrain_oe_n = r.od_oe_n;
  assign irq = r.irq;
  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;

  // ****************************************
  // checks
  // ****************************************
  default clocking covm_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_override_alarm: // RULE5
  assert property (!override_n |=> alarm_high_output)
  else $error("override low did not raise the alarm");

  chk_alarm_pins: // RULE6
  assert property (alarm_low_opendrain_oe_n == !alarm_high_output &&
    !alarm_low_opendrain_out)
  else $error("alarm pins disagree");

  chk_monitor_gate: // RULE7
  assert property (tif.sample |-> $past(regulator_recovered))
  else $error("sample tick before regulator recovery");

  chk_inactive_quiet: // RULE8
  assert property ((!top_cell_tap_active && override_n) |=> !alarm_high_output)
  else $error("alarm with the top cell inactive");

  chk_raise_cause: // RULE15
  assert property ((r.st == ST_ALARM && $past(r.st) == ST_NORMAL) |->
    $past(tif.done && top_cell_tap_active && mon_on))
  else $error("alarm raised without qualification");

  chk_active_raise: // RULE9
  assert property ((r.st == ST_NORMAL && tif.done && top_cell_tap_active && mon_on)
    |=> (r.st == ST_ALARM && alarm_high_output))
  else $error("qualified overvoltage did not raise the alarm");

  chk_alarm_period: // RULE2
  assert property ((r.st == ST_ALARM && !r.quick) |-> tif.period_cyc == ALARM_C)
  else $error("alarm state sample period wrong");

  chk_quick_timing: // RULE10
  assert property (r.quick |-> (tif.period_cyc == QUICK_C && tif.delay_cyc == QUICK_C))
  else $error("quick test timings wrong");

  chk_quick_entry: // RULE11
  assert property ($rose(r.quick) |-> $past(r.hold == HOLD_C && !override_n))
  else $error("quick test entered without the hold");

  chk_quick_exit: // RULE12
  assert property ($fell(r.quick) |-> $past(!override_n && r.seen_high))
  else $error("quick test left without high then low");
endmodule

// ### hdl/covm_pkg.sv
// package: constants and types of the cell overvoltage monitor
// assumes one clock domain at 125 MHz and a 32-bit register slave
package covm_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CYC_PER_MS = 125000; // clock cycles in one ms
  localparam int unsigned NORMAL_PERIOD_MS = 400;
  localparam int unsigned ALARM_PERIOD_MS = 100;
  localparam int unsigned QUICK_MS = 100;
  localparam int unsigned TEST_HOLD_MS = 25;
  localparam int unsigned DET_STEP_MS = 1000;
  localparam int unsigned REL_STEP_MS = 200;
  localparam int unsigned DET_STEPS_DEF = 2;
  localparam int unsigned REL_STEPS_DEF = 1;
  localparam int unsigned NORMAL_PERIOD_CYC = NORMAL_PERIOD_MS * CYC_PER_MS;
  localparam int unsigned ALARM_PERIOD_CYC = ALARM_PERIOD_MS * CYC_PER_MS;
  localparam int unsigned QUICK_CYC_DEF = QUICK_MS * CYC_PER_MS;
  localparam int unsigned TEST_HOLD_CYC_DEF = TEST_HOLD_MS * CYC_PER_MS;

  // ****************************************
  // register map
  // ****************************************
  localparam int unsigned REG_AW = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STS = 8'h08;
  localparam logic [7:0] REG_IRQ_EN = 8'h0C;
  localparam logic [7:0] REG_IRQ_CLR = 8'h10;
  localparam int unsigned CTRL_MON_EN = 0;
  localparam logic CTRL_MON_EN_RST = 1'h1;
  localparam int unsigned STS_W = 6;
  localparam int unsigned STS_ALARM = 0;
  localparam int unsigned STS_QUICK = 1;
  localparam int unsigned STS_MON = 2;
  localparam int unsigned STS_TOP_ACT = 3;
  localparam int unsigned STS_OVR_LOW = 4;
  localparam int unsigned STS_PIN = 5;
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_RAISE = 0;
  localparam int unsigned IRQ_RELEASE = 1;
  localparam int unsigned IRQ_QENTER = 2;
  localparam int unsigned IRQ_QEXIT = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_NORMAL, ST_ALARM} covm_state_e;
  typedef enum logic [2:0] {
    SEL_CTRL, SEL_STATUS, SEL_IRQ_STS, SEL_IRQ_EN, SEL_IRQ_CLR, SEL_NONE
  } covm_sel_e;

endpackage

// ### hdl/covm_time_if.sv
// interface: sample tick and delay qualification between core and helpers
// assumes every signal lives in the aclk domain
`timescale 1ns/1ps
interface covm_time_if #(parameter int unsigned CNT_W = 32);
  logic run_en; // sampling allowed
  logic [CNT_W-1:0] period_cyc; // sample period in cycles
  logic sample; // one-cycle sample tick
  logic cond; // condition under qualification
  logic restart; // drop any qualification in progress
  logic [CNT_W-1:0] delay_cyc; // qualifying delay in cycles
  logic done; // one-cycle qualified pulse
  modport sampler (input run_en, input period_cyc, output sample);
  modport qual (input sample, input cond, input restart, input delay_cyc, output done);
endinterface

// ### hdl/covm_sampler.sv
// sample tick generator for the cell monitor cycle
// assumes a period of at least two cycles, driven by the core
`timescale 1ns/1ps
module covm_sampler
  import covm_pkg::*;
#(
  parameter int unsigned CNT_W = 32
) (
  input logic aclk, // clock
  input logic aresetn, // synchronous reset, active low
  covm_time_if.sampler t // period in, tick out
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic sample;
  } covm_smp_s;
  covm_smp_s r, n;
  logic [CNT_W-1:0] gap, last_per;
  logic gap_ok;

  // count the period and pulse at its end
  always_comb begin
    n = r;
    n.sample = 1'b0;
    if (!t.run_en) begin
      n.cnt = '0;
    end else if (r.cnt >= t.period_cyc - 1'b1) begin
      n.cnt = '0;
      n.sample = 1'b1;
    end else begin
      n.cnt = r.cnt + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) r <= '0;
    else r <= n;
  end

  assign t.sample = r.sample;

  // gap between ticks while the period stands still
  always_ff @(posedge aclk) begin
    last_per <= t.period_cyc;
    gap <= r.sample ? '0 : gap + 1'b1;
    if (!aresetn || !t.run_en || t.period_cyc != last_per) gap_ok <= 1'b0;
    else if (r.sample) gap_ok <= 1'b1;
  end

  chk_sample_period: // RULE1
  assert property (@(posedge aclk) disable iff (!aresetn)
    (r.sample && gap_ok && t.period_cyc == last_per) |-> gap == t.period_cyc - 1'b1)
  else $error("sample tick spacing differs from the period");
endmodule

// ### hdl/covm_qualifier.sv
// delay qualifier: a condition seen at every tick for a whole delay
// assumes the core restarts it whenever the alarm state changes
`timescale 1ns/1ps
module covm_qualifier
  import covm_pkg::*;
#(
  parameter int unsigned CNT_W = 32
) (
  input logic aclk, // clock
  input logic aresetn, // synchronous reset, active low
  covm_time_if.qual t // condition in, qualified pulse out
);
  typedef struct packed {
    logic run;
    logic [CNT_W-1:0] cnt;
    logic done;
  } covm_qual_s;
  covm_qual_s r, n;

  // time since the first qualifying tick, judged only at ticks
  always_comb begin
    n = r;
    n.done = 1'b0;
    if (r.run && r.cnt != '1) n.cnt = r.cnt + 1'b1;
    if (t.restart) begin
      n.run = 1'b0;
      n.cnt = '0;
    end else if (t.sample) begin
      // [RULE16] miss restarts count
      if (!t.cond) begin
        n.run = 1'b0;
        n.cnt = '0;
      end else if (!r.run) begin
        n.run = 1'b1;
        n.cnt = '0;
      // [RULE4] only at ticks
      end else if (r.cnt >= t.delay_cyc) begin
        n.done = 1'b1;
        n.run = 1'b0;
        n.cnt = '0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) r <= '0;
    else r <= n;
  end

  assign t.done = r.done;

  chk_qual_delay: // RULE3
  assert property (@(posedge aclk) disable iff (!aresetn)
    t.done |-> $past(r.run && t.sample && t.cond && r.cnt >= t.delay_cyc))
  else $error("qualified before the full delay");

  chk_qual_restart: // RULE16
  assert property (@(posedge aclk) disable iff (!aresetn)
    (t.restart || (t.sample && !t.cond)) |=> (!r.run && r.cnt == '0 && !t.done))
  else $error("broken qualification kept counting");
endmodule

// ### testbench/covm_cell_pack.sv
// partner: cell stack, top tap and pull-up on the open-drain alarm wire
// assumes levels are commanded by the bench in the aclk domain
`timescale 1ns/1ps
module covm_cell_pack (
  input logic aclk, // clock
  input logic over_cmd, // bench drives a cell above detect level
  input logic top_cmd, // bench connects the top cell
  input logic od_out, // monitor open-drain value
  input logic od_oe_n, // monitor open-drain enable, low pulls
  output logic cell_over, // some cell above detect level
  output logic cell_below, // all cells below release level
  output logic top_active, // top tap above activation level
  output logic od_pin // resolved open-drain wire
);
  // comparator levels settle one edge after the bench moves them
  // over and below never both high
  always_ff @(posedge aclk) begin
    cell_over <= over_cmd;
    cell_below <= !over_cmd;
    top_active <= top_cmd;
  end
  // pull-up holds the wire high when released
  assign od_pin = (od_oe_n === 1'b0) ? od_out : 1'b1;
endmodule

// ### testbench/cell_overvoltage_monitor_bench.sv
// bench: register tasks over the bus, alarm timing and quick test checks
// assumes covm_top with short periods and the cell pack partner
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module cell_overvoltage_monitor_bench;
  import covm_pkg::*;
  localparam int NC = 40;
  localparam int AC = 10;
  localparam int QC = 8;
  localparam int TH = 5;
  localparam int DC = 100;
  localparam int RC = 20;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic regulator_recovered = 1'b0;
  logic override_n = 1'b0;
  logic over_cmd = 1'b0;
  logic top_cmd = 1'b0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd;
  logic [1:0] rsp, wrsp;
  logic cell_over, cell_below, top_active, od_pin, od_out, od_oe_n;
  logic alarm_high_output, irq;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int n;

  covm_top #(.NORMAL_CYC(NC), .ALARM_CYC(AC), .QUICK_CYC(QC), .TEST_HOLD_CYC(TH),
    .DET_CYC(DC), .REL_CYC(RC)) dut (.aclk(aclk), .aresetn(aresetn),
    .cell_over_detect(cell_over), .cell_below_release(cell_below),
    .top_cell_tap_active(top_active), .regulator_recovered(regulator_recovered),
    .override_n(override_n), .alarm_low_opendrain_in(od_pin),
    .alarm_low_opendrain_out(od_out), .alarm_low_opendrain_oe_n(od_oe_n),
    .alarm_high_output(alarm_high_output), .irq(irq),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));

  covm_cell_pack pack (.aclk(aclk), .over_cmd(over_cmd), .top_cmd(top_cmd),
    .od_out(od_out), .od_oe_n(od_oe_n), .cell_over(cell_over),
    .cell_below(cell_below), .top_active(top_active), .od_pin(od_pin));

  // ****************************************
  // clock, timeout and verdict
  // ****************************************
  always #4 aclk = ~aclk;

  // cut a hang short
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****************************************
  // bus and timing tasks
  // ****************************************
  // write: hold each channel until its ready, bready until bvalid
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, b_ok;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_bready <= 1'b1;
    // readies sampled mid-cycle stand at the next rising edge
    do begin
      @(negedge aclk);
      aw_ok = s_axi_awready;
      w_ok = s_axi_wready;
      b_ok = s_axi_bvalid;
      wrsp = s_axi_bresp;
      @(posedge aclk);
      if (aw_ok === 1'b1) s_axi_awvalid <= 1'b0;
      if (w_ok === 1'b1) s_axi_wvalid <= 1'b0;
    end while (b_ok !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask

  // read: data and response taken at the rvalid edge
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_ok, r_ok;
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar_ok = s_axi_arready;
      r_ok = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar_ok === 1'b1) s_axi_arvalid <= 1'b0;
    end while (r_ok !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    axi_rd(a, rd, rsp);
    `CHK(nm, e, rd)
  endtask

  // cycles until the alarm output reaches a level
  task automatic wait_alarm(input logic tgt, output int cnt);
    cnt = 0;
    @(negedge aclk);
    while (alarm_high_output !== tgt && cnt < 2000) begin
      @(negedge aclk);
      cnt++;
    end
    @(posedge aclk);
  endtask

  task automatic rng(input string nm, input int v, input int lo, input int hi);
    `CHK(nm, 1'b1, (v >= lo && v <= hi))
  endtask

  // move the cell level and time the alarm edge
  task automatic step(input logic ov, output int cnt);
    @(posedge aclk);
    over_cmd <= ov;
    wait_alarm(ov, cnt);
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rdc(REG_CTRL, 32'h1, "ctrl reset");
    rdc(REG_IRQ_EN, 32'h0, "irq enable reset");
    axi_rd(8'h14, rd, rsp);
    `CHK("unmapped resp", RESP_SLVERR, rsp)
    axi_wr(REG_IRQ_EN, 32'hF);
    `CHK("write resp", RESP_OKAY, wrsp)
    axi_wr(8'h14, 32'h0);
    `CHK("unmapped wresp", RESP_SLVERR, wrsp)
    `CHK("forced alarm", 1'b1, alarm_high_output)
    `CHK("forced pin", 1'b0, od_pin)
    rdc(REG_STATUS, 32'h10, "status forced");
    @(posedge aclk);
    regulator_recovered <= 1'b1;
    repeat (TH + 10) @(posedge aclk);
    axi_rd(REG_STATUS, rd, rsp);
    `CHK("quick entered", 1'b1, rd[STS_QUICK])
    override_n <= 1'b1;
    top_cmd <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK("normal alarm", 1'b0, alarm_high_output)
    `CHK("normal pin", 1'b1, od_pin)
    step(1'b1, n);
    rng("quick raise", n, QC, 3 * QC + 6);
    step(1'b0, n);
    rng("quick release", n, QC, 3 * QC + 6);
    override_n <= 1'b0;
    axi_rd(REG_STATUS, rd, rsp);
    `CHK("quick left", 1'b0, rd[STS_QUICK])
    `CHK("irq level", 1'b1, irq)
    rdc(REG_IRQ_STS, 32'hF, "irq events");
    override_n <= 1'b1;
    axi_wr(REG_IRQ_CLR, 32'hF);
    axi_wr(REG_IRQ_EN, 32'h1);
    rdc(REG_IRQ_STS, 32'h0, "irq cleared");
    `CHK("irq low", 1'b0, irq)
    step(1'b1, n);
    rng("raise delay", n, DC, DC + 2 * NC + 6);
    `CHK("irq raised", 1'b1, irq)
    step(1'b0, n);
    rng("release delay", n, RC, RC + 2 * AC + 6);
    over_cmd <= 1'b1;
    repeat (90) @(posedge aclk);
    over_cmd <= 1'b0;
    repeat (60) @(posedge aclk);
    `CHK("broken detect", 1'b0, alarm_high_output)
    step(1'b1, n);
    rng("restart delay", n, DC, DC + 2 * NC + 6);
    step(1'b0, n);
    top_cmd <= 1'b0;
    over_cmd <= 1'b1;
    repeat (300) @(posedge aclk);
    `CHK("top inactive", 1'b0, alarm_high_output)
    top_cmd <= 1'b1;
    wait_alarm(1'b1, n);
    rng("top active raise", n, DC, DC + 2 * NC + 6);
    step(1'b0, n);
    regulator_recovered <= 1'b0;
    over_cmd <= 1'b1;
    repeat (300) @(posedge aclk);
    `CHK("no regulator", 1'b0, alarm_high_output)
    axi_rd(REG_STATUS, rd, rsp);
    `CHK("monitor off", 1'b0, rd[STS_MON])
    regulator_recovered <= 1'b1;
    axi_wr(REG_CTRL, 32'h0);
    axi_rd(REG_STATUS, rd, rsp);
    `CHK("ctrl off", 1'b0, rd[STS_MON])
    override_n <= 1'b0;
    repeat (3) @(posedge aclk);
    `CHK("forced again", 1'b1, alarm_high_output)
    final_report();
  end
endmodule
